// *** verif/adc_conv_model.sv ***
`timescale 1ns/100ps
module adc_conv_model #(
    parameter DATA_W = 12
) (
    input wire clk,
    input wire rstn,
    input wire conv_start,
    input wire [3:0] conv_channel,
    output reg [DATA_W-1:0] adc_result,
    output reg adc_done
);
    reg [7:0] num_r; // results delivered so far
    reg [3:0] ch_r; // channel of the running conversion
    reg [4:0] left_r; // cycles to go, zero when idle
    // fixed 20-cycle conversion; result carries its sequence number and channel
    always @(posedge clk) begin
        adc_done <= 1'b0;
        // outside a result the bus toggles so stale data never looks valid
        adc_result <= ~adc_result;
        if (!rstn) begin
            num_r <= 8'h00;
            ch_r <= 4'h0;
            left_r <= 5'h00;
            adc_result <= {DATA_W{1'b0}};
        end else if (conv_start) begin
            ch_r <= conv_channel;
            left_r <= 5'h14;
        end else if (left_r != 5'h00) begin
            left_r <= left_r - 5'h01;
            if (left_r == 5'h01) begin
                adc_done <= 1'b1;
                adc_result <= {num_r, ch_r};
                num_r <= num_r + 8'h01;
            end
        end
    end
endmodule

// *** verif/adc_seq_properties.sv ***
`timescale 1ns/100ps
module adc_seq_checker #(
    parameter DATA_W = 12
) (
    input wire core_clk,
    input wire rstn,
    input wire cs_n,
    input wire frame_sync,
    input wire sclk,
    input wire serial_data_in,
    input wire conversion_start_n,
    input wire [DATA_W-1:0] adc_result,
    input wire adc_done,
    input wire serial_data_out,
    input wire sdo_oe,
    input wire int_eoc_n,
    input wire conv_start,
    input wire [3:0] conv_channel,
    input wire sampling
);
    // ********
    // converter busy tracking
    // ********
    reg busy_r; // a conversion is running
    always @(posedge core_clk) begin
        if (!rstn) begin
            busy_r <= 1'b0;
        end else if (conv_start) begin
            busy_r <= 1'b1;
        end else if (adc_done) begin
            busy_r <= 1'b0;
        end
    end
    // ********
    // properties
    // ********
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence cs_idle6;
        cs_n [*6];
    endsequence
    sequence int_held;
        !int_eoc_n [*2];
    endsequence
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conversion start wider than one cycle");
    busy_guard_a: assert property (conv_start |-> !busy_r)
        else $error("conversion started while busy");
    chan_hold_a: assert property (!conv_start |-> $stable(conv_channel))
        else $error("channel moved without a start");
    oe_select_a: assert property ($rose(sdo_oe) |-> !$past(cs_n, 2))
        else $error("output enabled without chip select");
    oe_release_a: assert property (cs_idle6 |-> !sdo_oe)
        else $error("output still driven after deselect");
    int_once_a: assert property ($fell(int_eoc_n) |=> int_held)
        else $error("interrupt not held");
    int_cause_a: assert property ($fell(int_eoc_n) |->
        $past(adc_done | conv_start) || $past(adc_done | conv_start, 2)
        || $past(adc_done, 3))
        else $error("status pin fell without a conversion event");
    sample_win_a: assert property ($rose(sampling) |-> cs_n && !conversion_start_n)
        else $error("sampling outside start low with select high");
    start_rise_a: assert property ($fell(sampling) && cs_n |-> ##[0:4] conv_start)
        else $error("start pin rise did not convert");
endmodule
bind adc_serial_sequencer_fifo adc_seq_checker #(.DATA_W(DATA_W)) i_adc_seq_checker (
    .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .frame_sync(frame_sync),
    .sclk(sclk), .serial_data_in(serial_data_in),
    .conversion_start_n(conversion_start_n), .adc_result(adc_result),
    .adc_done(adc_done), .serial_data_out(serial_data_out), .sdo_oe(sdo_oe),
    .int_eoc_n(int_eoc_n), .conv_start(conv_start), .conv_channel(conv_channel),
    .sampling(sampling));

// *** verif/adc_serial_sequencer_fifo_test.sv ***
`timescale 1ns/100ps
`include "adc_seq_map.vh"
module adc_serial_sequencer_fifo_test;
    // ********
    // pins and bench state
    // ********
    reg core_clk = 1'b0;
    reg rstn = 1'b0;
    reg cs_n = 1'b1;
    reg frame_sync = 1'b0;
    reg sclk = 1'b0; // link clock, stands low between groups
    reg serial_data_in = 1'b0;
    reg conversion_start_n = 1'b1;
    wire [11:0] adc_result;
    wire adc_done;
    wire serial_data_out;
    wire sdo_oe;
    wire int_eoc_n;
    wire conv_start;
    wire [3:0] conv_channel;
    wire sampling;
    integer miscompares = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer ncs = 0; // conversion pulses seen
    integer i;
    reg [7:0] ncv = 8'h00; // conversions triggered by the bench
    reg [7:0] n0;
    reg oe_seen; // output enable seen since the last frame began
    reg [15:0] rd; // bits captured in last group
    adc_serial_sequencer_fifo i_adc_serial_sequencer_fifo (
        .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .frame_sync(frame_sync),
        .sclk(sclk), .serial_data_in(serial_data_in),
        .conversion_start_n(conversion_start_n), .adc_result(adc_result),
        .adc_done(adc_done), .serial_data_out(serial_data_out), .sdo_oe(sdo_oe),
        .int_eoc_n(int_eoc_n), .conv_start(conv_start), .conv_channel(conv_channel),
        .sampling(sampling));
    adc_conv_model i_adc_conv_model (.clk(core_clk), .rstn(rstn), .conv_start(conv_start),
        .conv_channel(conv_channel), .adc_result(adc_result), .adc_done(adc_done));
    always #2 core_clk = ~core_clk;
    // cycle ceiling and conversion pulse count
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (conv_start === 1'b1) ncs = ncs + 1;
        if (cyc == 60000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    // ********
    // tasks
    // ********
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // one 16-clock group, msb first; output sampled just before each rise
    task shift16(input [15:0] w);
        integer k;
        begin
            for (k = 15; k >= 0; k = k - 1) begin
                serial_data_in = w[k];
                #62.5;
                rd[k] = serial_data_out;
                oe_seen = oe_seen | sdo_oe;
                sclk = 1'b1;
                #62.5;
                sclk = 1'b0;
            end
        end
    endtask
    // select-framed transfer; the offset keeps link edges off the core edges
    task frame(input [15:0] w);
        begin
            @(negedge core_clk);
            oe_seen = 1'b0;
            cs_n = 1'b0;
            #0.75;
            shift16(w);
            #62.5;
            cs_n = 1'b1;
            repeat (40) @(negedge core_clk);
        end
    endtask
    // n trigger frames, each one conversion
    task trig(input [15:0] w, input integer n);
        begin
            repeat (n) begin
                frame(w);
                ncv = ncv + 8'h01;
            end
            chk(ncs, ncv);
            chk(int_eoc_n, 1'b0);
        end
    endtask
    // four reads in one select with frame sync high, clock paused between;
    // without a preload the first entry follows the command nibble
    task drain(input pre, input [7:0] f, input [3:0] c0, input [3:0] step);
        begin
            @(negedge core_clk);
            frame_sync = 1'b1;
            cs_n = 1'b0;
            #0.75;
            for (i = 0; i < 4; i = i + 1) begin
                shift16({`CMD_RD_FIFO, 12'h000});
                chk((pre || i != 0) ? rd[15:4] : rd[11:0],
                    {f + i[7:0], c0 + step * i[3:0]});
                chk(ncs, ncv);
                #300;
            end
            cs_n = 1'b1;
            frame_sync = 1'b0;
            repeat (40) @(negedge core_clk);
            chk(int_eoc_n, 1'b1);
        end
    endtask
    // ********
    // test sequence
    // ********
    initial begin
        repeat (8) @(negedge core_clk);
        chk({serial_data_out, sdo_oe, int_eoc_n, conv_start, conv_channel, sampling}, 9'h040);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        frame({`CMD_WR_CFG, 12'h207});
        frame({`CMD_RD_CFG, 12'h000});
        chk(rd[11:0], 12'h207);
        chk(ncs, 0);
        $display("test config done");
        // repeat mode: refused read, non-read after threshold, then drain
        frame({`CMD_WR_CFG, 12'h022});
        frame({`CMD_RD_CFG, 12'h000});
        chk(oe_seen, 1'b0);
        n0 = ncv;
        trig(16'h3000, 4);
        frame({`CMD_RD_CFG, 12'h000});
        chk({oe_seen, sdo_oe}, 2'b10);
        drain(1'b0, n0, 4'h3, 4'h0);
        $display("test repeat done");
        frame({`CMD_WR_CFG, 12'h052});
        n0 = ncv;
        trig(16'h0000, 4);
        drain(1'b1, n0, 4'h0, 4'h2);
        $display("test sweep done");
        // ignored threshold: next select clears and the sweep carries on
        frame({`CMD_WR_CFG, 12'h062});
        trig(16'h0000, 4);
        n0 = ncv;
        trig(16'h0000, 4);
        drain(1'b1, n0, 4'h0, 4'h1);
        $display("test repeat sweep done");
        frame({`CMD_WR_CFG, 12'h422});
        frame(16'h5000);
        n0 = ncv;
        for (i = 0; i < 4; i = i + 1) begin
            conversion_start_n = 1'b0;
            repeat (20) @(negedge core_clk);
            chk(sampling, 1'b1);
            conversion_start_n = 1'b1;
            ncv = ncv + 8'h01;
            repeat (40) @(negedge core_clk);
        end
        chk(ncs, ncv);
        chk(int_eoc_n, 1'b0);
        drain(1'b1, n0, 4'h5, 4'h0);
        $display("test extended done");
        // long sampling: a select frame converts only after clock 28
        frame({`CMD_WR_CFG, 12'h200});
        @(negedge core_clk);
        cs_n = 1'b0;
        #0.75;
        shift16(16'h1000);
        chk(ncs, ncv);
        shift16(16'h0000);
        ncv = ncv + 8'h01;
        #62.5;
        cs_n = 1'b1;
        repeat (40) @(negedge core_clk);
        chk(ncs, ncv);
        // single shot extended: the start rise after a select converts once
        frame({`CMD_WR_CFG, 12'h400});
        frame(16'h2000);
        n0 = ncv;
        conversion_start_n = 1'b0;
        repeat (20) @(negedge core_clk);
        conversion_start_n = 1'b1;
        ncv = ncv + 8'h01;
        repeat (8) @(negedge core_clk);
        chk(int_eoc_n, 1'b0);
        repeat (40) @(negedge core_clk);
        chk({ncs[7:0], int_eoc_n}, {ncv, 1'b1});
        // depth one: the lone result reaches the threshold and preloads
        frame({`CMD_RD_FIFO, 12'h000});
        chk(rd[15:4], {n0, 4'h2});
        $display("test single shot done");
        final_report;
    end
endmodule

// *** verilog/adc_seq_map.vh ***
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
// ************************************************************
// configuration register layout
// ************************************************************
`define CFG_W 12
`define CFG_RESET 12'h000
`define CFG_THR_HI 1
`define CFG_THR_LO 0
`define CFG_INT_FN 2
`define CFG_SEQ_HI 4
`define CFG_SEQ_LO 3
`define CFG_MODE_HI 6
`define CFG_MODE_LO 5
`define CFG_LONG 9
`define CFG_EXT 10
// ************************************************************
// conversion modes
// ************************************************************
`define MODE_SINGLE 2'h0
`define MODE_REPEAT 2'h1
`define MODE_SWEEP 2'h2
`define MODE_RSWEEP 2'h3
// ************************************************************
// serial commands, top nibble of each frame
// ************************************************************
`define CMD_RD_CFG 4'h9
`define CMD_WR_CFG 4'ha
`define CMD_RD_FIFO 4'he
// ************************************************************
// frame timing in serial clock edges, fifo depth and synchroniser reset value
// ************************************************************
`define DECODE_EDGE 5'h03
`define WORD_EDGE 5'h0f
`define SHORT_EDGE 5'h0f
`define LONG_EDGE 5'h1b
`define FIFO_DEPTH 8
`define SYNC_RESET 5'h11
`endif

// *** verilog/adc_serial_sequencer_fifo.v ***
// What this block does
// R1 - mode 01 repeats conversions of one channel
// R2 - mode 10 converts each sequence channel once
// R3 - mode 11 cycles the sequence repeatedly
// R4 - exactly one interrupt at fifo threshold
// R5 - unread fifo cleared when host ignores interrupt
// R6 - extended sampling: start pin triggers, chip select high
// R7 - config read: decode four clocks, then shift out
// R8 - config read honored only in mode 00
// R9 - first command after interrupt taken as fifo read
// R10 - oldest entry shifts out before command decode
// R11 - other command stops output; outside mode 11 only a non-select, non-write command keeps the oldest entry
// R12 - fifo read starts no conversion or interrupt
// R13 - back-to-back fifo reads in 16-clock groups
// R14 - write cycle loads twelve bit configuration
// R15 - write cycle starts nothing, signals nothing
// R16 - host holds chip select low six clocks
// R17 - host waits six clocks before start pin
// R18 - sampling only while start low, select high
// R19 - single-shot extended converts on next start rise
// R20 - eight entry fifo, fractional threshold
// R21 - fifo keeps results in arrival order
// R22 - single-shot forces depth one, ignores bits 1:0
// R23 - normal trigger starts after edge 16 or 28
// R24 - repeat sweep clears fifo and carries on
// R25 - status pin is end-of-conversion only in mode 00
// R26 - interrupt released when servicing read begins
`timescale 1ns/100ps
`include "adc_seq_map.vh"
module adc_serial_sequencer_fifo #(
    parameter DATA_W = 12
) (
    input wire core_clk,
    input wire rstn,
    input wire cs_n,
    input wire frame_sync,
    input wire sclk,
    input wire serial_data_in,
    input wire conversion_start_n,
    input wire [DATA_W-1:0] adc_result,
    input wire adc_done,
    output reg serial_data_out,
    output reg sdo_oe,
    output reg int_eoc_n,
    output reg conv_start,
    output reg [3:0] conv_channel,
    output reg sampling
);

    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    wire [4:0] pin_vec;      // {cs_n, frame_sync, sclk, sdi, start_n}
    reg [4:0] meta_r;        // first stage, read only by sync_r
    reg [4:0] sync_r;        // settled pin levels
    reg [4:0] dly_r;         // one cycle older, for edges
    assign pin_vec = {cs_n, frame_sync, sclk, serial_data_in, conversion_start_n};
    // two flops per pin before anything looks at it
    always @(posedge core_clk) begin
        if (!rstn) begin
            meta_r <= `SYNC_RESET;
            sync_r <= `SYNC_RESET;
            dly_r <= `SYNC_RESET;
        end else begin
            meta_r <= pin_vec;
            sync_r <= meta_r;
            dly_r <= sync_r;
        end
    end
    wire cs_s = sync_r[4];
    wire sdi_s = sync_r[1];
    wire cst_s = sync_r[0];
    wire cs_fall = ~sync_r[4] & dly_r[4];
    wire cs_rise = sync_r[4] & ~dly_r[4];
    wire fs_rise = sync_r[3] & ~dly_r[3];
    wire sclk_rise = sync_r[2] & ~dly_r[2];
    wire sclk_fall = ~sync_r[2] & dly_r[2];
    wire cst_rise = sync_r[0] & ~dly_r[0];
    wire cst_fall = ~sync_r[0] & dly_r[0];
    // ************************************************************
    // state
    // ************************************************************
    reg [`CFG_W-1:0] cfg_r;        // configuration register
    reg frame_r;                   // serial frame in progress
    reg [4:0] bit_cnt_r;           // rising sclk edges this frame
    reg [15:0] in_sh_r;            // incoming serial word
    reg [3:0] cmd_r;               // decoded command nibble
    reg [15:0] out_sh_r;           // outgoing bits, msb next
    reg rd_frame_r;                // frame is reading the fifo
    reg sel_frame_r;               // frame carries a channel select
    reg int_r;                     // interrupt pending
    reg armed_r;                   // threshold already signalled
    reg after_int_r;               // next frame is first after interrupt
    reg busy_r;                    // conversion in flight
    reg [3:0] chan_r;              // selected fixed channel
    reg [1:0] seq_idx_r;           // sweep position
    reg halt_r;                    // single sweep finished
    reg ext_arm_r;                 // single-shot waits on start pin
    reg [DATA_W-1:0] fifo_r [0:`FIFO_DEPTH-1];
    reg [2:0] wr_ptr_r;
    reg [2:0] rd_ptr_r;
    reg [3:0] count_r;
    wire [1:0] mode = cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
    wire single = (mode == `MODE_SINGLE);
    wire sweeping = mode[1];
    wire ext_smp = cfg_r[`CFG_EXT];
    // ************************************************************
    // sweep sequence table and threshold decode
    // ************************************************************
    // four fixed four-step sequences; small lookup beats a ram here
    function [3:0] seq_chan;
        input [1:0] sel;
        input [1:0] idx;
        begin
            case (sel)
                2'h0: seq_chan = {2'h0, idx};
                2'h1: seq_chan = {2'h1, idx};
                2'h2: seq_chan = {1'h0, idx, 1'h0};
                default: seq_chan = {1'h0, idx, 1'h1};
            endcase
        end
    endfunction
    reg [3:0] thr;   // results needed for the interrupt
    always @* begin
        if (single) begin
            thr = 4'h1;                                          // R22
        end else begin
            case (cfg_r[`CFG_THR_HI:`CFG_THR_LO])                // R20
                2'h0: thr = 4'h8;
                2'h1: thr = 4'h6;
                2'h2: thr = 4'h4;
                default: thr = 4'h2;
            endcase
        end
    end

    // ************************************************************
    // frame decode strobes
    // ************************************************************
    wire rise_in = frame_r & sclk_rise;
    wire [3:0] cmd_now = {in_sh_r[2:0], sdi_s};
    wire at_decode = rise_in & (bit_cnt_r == `DECODE_EDGE);
    wire at_word = rise_in & (bit_cnt_r == `WORD_EDGE);
    wire is_rd_fifo = (cmd_now == `CMD_RD_FIFO);
    wire is_select = ~cmd_now[3];
    wire [4:0] trig_edge = cfg_r[`CFG_LONG] ? `LONG_EDGE : `SHORT_EDGE;
    // normal trigger from a select frame, extended from the start pin
    wire norm_trig = rise_in & sel_frame_r & ~ext_smp & (bit_cnt_r == trig_edge); // R23
    wire ext_trig = cst_rise & cs_s & ext_smp & (~single | ext_arm_r);     // R6 R19
    wire start_ok = ~busy_r & ~halt_r & (norm_trig | ext_trig);
    // ************************************************************
    // fifo bookkeeping
    // ************************************************************
    wire do_push = adc_done & busy_r;
    wire push_ok = do_push & (count_r != 4'h8);
    wire do_pop = at_word & rd_frame_r & (count_r != 4'h0);
    // ignored interrupt: new select, write or any command in mode 11
    wire clr_cmd = at_decode & after_int_r & ~is_rd_fifo &
                   (mode == `MODE_RSWEEP | is_select);                    // R5 R24
    wire clr_start = after_int_r & cst_fall & ext_smp & (mode == `MODE_RSWEEP); // R24
    wire clr_wr = at_word & (cmd_r == `CMD_WR_CFG);                       // R5
    // depth one in single shot: each result replaces the last
    wire clr_single = single & push_ok;                                    // R22
    wire clr = clr_cmd | clr_start | clr_wr | clr_single;
    reg [3:0] cnt_nxt;
    always @* begin
        if (clr) begin
            cnt_nxt = {3'h0, push_ok};
        end else begin
            cnt_nxt = count_r + {3'h0, push_ok} - {3'h0, do_pop};
        end
    end
    wire [2:0] wr_base = clr ? rd_ptr_r + count_r[2:0] : wr_ptr_r;
    wire hit_thr = push_ok & (cnt_nxt >= thr) & ~armed_r;                 // R4
    // fifo storage, written at the tail in arrival order
    always @(posedge core_clk) begin
        if (push_ok) begin
            fifo_r[wr_base] <= adc_result;                                // R21
        end
    end
    // pointers and level
    always @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr_r <= 3'h0;
            rd_ptr_r <= 3'h0;
            count_r <= 4'h0;
        end else begin
            if (clr) begin
                // drop everything before the new result
                rd_ptr_r <= wr_base;
            end else if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 3'h1;
            end
            if (push_ok) begin
                wr_ptr_r <= wr_base + 3'h1;
            end else if (clr) begin
                wr_ptr_r <= wr_base;
            end
            count_r <= cnt_nxt;
        end
    end

    // ************************************************************
    // serial frame engine
    // ************************************************************
    wire [DATA_W-1:0] head = fifo_r[rd_ptr_r];
    wire [DATA_W-1:0] next_head = fifo_r[rd_ptr_r + 3'h1];
    always @(posedge core_clk) begin
        if (!rstn) begin
            cfg_r <= `CFG_RESET;
            frame_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            in_sh_r <= 16'h0000;
            cmd_r <= 4'h0;
            out_sh_r <= 16'h0000;
            serial_data_out <= 1'b0;
            sdo_oe <= 1'b0;
            rd_frame_r <= 1'b0;
            sel_frame_r <= 1'b0;
            chan_r <= 4'h0;
            ext_arm_r <= 1'b0;
        end else if (cs_rise) begin
            // frame over: release the output, drop frame context
            frame_r <= 1'b0;
            sdo_oe <= 1'b0;
            rd_frame_r <= 1'b0;
            sel_frame_r <= 1'b0;
        end else if (cs_fall | (fs_rise & ~cs_s)) begin
            frame_r <= 1'b1;
            bit_cnt_r <= 5'h00;
            sel_frame_r <= 1'b0;
            rd_frame_r <= 1'b0;
            // after an interrupt the oldest result goes out at once
            if (after_int_r & (count_r != 4'h0)) begin
                serial_data_out <= head[DATA_W-1];                        // R9 R10
                out_sh_r <= {head[DATA_W-2:0], 5'h00};
                sdo_oe <= 1'b1;
            end else begin
                sdo_oe <= 1'b0;
            end
        end else if (rise_in) begin
            in_sh_r <= {in_sh_r[14:0], sdi_s};
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (at_decode) begin
                cmd_r <= cmd_now;                                         // R7
                if (is_rd_fifo & (count_r != 4'h0)) begin
                    rd_frame_r <= 1'b1;                                   // R12
                    if (!sdo_oe) begin
                        out_sh_r <= {head, 4'h0};
                        sdo_oe <= 1'b1;
                    end
                end else if ((cmd_now == `CMD_RD_CFG) & single) begin
                    out_sh_r <= {cfg_r, 4'h0};                            // R7 R8
                    sdo_oe <= 1'b1;
                end else begin
                    sdo_oe <= 1'b0;                                       // R11
                end
                if (is_select) begin
                    chan_r <= cmd_now;
                    sel_frame_r <= 1'b1;
                    ext_arm_r <= 1'b1;                                    // R19
                end
            end
            if (at_word) begin
                if (cmd_r == `CMD_WR_CFG) begin
                    cfg_r <= {in_sh_r[10:0], sdi_s};                      // R14 R15
                end
                if (rd_frame_r) begin
                    // keep reading in 16-edge groups while selected
                    bit_cnt_r <= 5'h00;                                   // R13
                    in_sh_r <= 16'h0000;
                    if (count_r > 4'h1) begin
                        out_sh_r <= {next_head, 4'h0};
                    end else begin
                        rd_frame_r <= 1'b0;
                        sdo_oe <= 1'b0;
                    end
                end
            end
        end else if (frame_r & sclk_fall & sdo_oe) begin
            // data changes on the falling edge, host samples on rising
            serial_data_out <= out_sh_r[15];
            out_sh_r <= {out_sh_r[14:0], 1'b0};
        end else if (ext_trig & start_ok) begin
            ext_arm_r <= 1'b0;
        end
    end

    // ************************************************************
    // conversion sequencing and interrupt
    // ************************************************************
    always @(posedge core_clk) begin
        if (!rstn) begin
            busy_r <= 1'b0;
            conv_start <= 1'b0;
            conv_channel <= 4'h0;
            seq_idx_r <= 2'h0;
            halt_r <= 1'b0;
            int_r <= 1'b0;
            armed_r <= 1'b0;
            after_int_r <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            if (clr_wr) begin
                // new mode: sweep starts over from its first channel
                seq_idx_r <= 2'h0;
                halt_r <= 1'b0;
            end else if (start_ok) begin
                busy_r <= 1'b1;
                conv_start <= 1'b1;
                conv_channel <= sweeping ?
                    seq_chan(cfg_r[`CFG_SEQ_HI:`CFG_SEQ_LO], seq_idx_r) : chan_r;  // R1 R2 R3
            end else if (do_push) begin
                busy_r <= 1'b0;
                if (sweeping) begin
                    seq_idx_r <= seq_idx_r + 2'h1;                        // R3
                    // one pass only in sweep mode
                    if ((mode == `MODE_SWEEP) & (seq_idx_r == 2'h3)) begin
                        halt_r <= 1'b1;                                   // R2
                    end
                end
            end
            // sweep may restart once the host has drained the fifo
            if (halt_r & (cnt_nxt == 4'h0) & do_pop) begin
                halt_r <= 1'b0;
            end
            // hardware set wins over any release in the same cycle
            if (hit_thr) begin
                int_r <= 1'b1;                                            // R4
                armed_r <= 1'b1;
                after_int_r <= 1'b1;
            end else begin
                if (at_decode & after_int_r) begin
                    after_int_r <= 1'b0;                                  // R9
                end
                // a read after a refused command still services the pin
                if (at_decode & is_rd_fifo) begin
                    int_r <= 1'b0;                                        // R26
                end
                if (clr_cmd | clr_start | clr_wr) begin
                    int_r <= 1'b0;
                    after_int_r <= 1'b0;
                end
                if (cnt_nxt < thr) begin
                    armed_r <= 1'b0;                                      // R26
                end
            end
        end
    end
    // ************************************************************
    // status pin and sampling indication
    // ************************************************************
    always @(posedge core_clk) begin
        if (!rstn) begin
            int_eoc_n <= 1'b1;
            sampling <= 1'b0;
        end else begin
            // end of conversion only in single shot with that function
            if (single & ~cfg_r[`CFG_INT_FN]) begin
                int_eoc_n <= ~busy_r;                                     // R25
            end else begin
                int_eoc_n <= ~int_r;                                      // R25
            end
            // overlap with chip select low does not count
            sampling <= ext_smp & ~cst_s & cs_s & ~busy_r;                // R18
        end
    end

endmodule
